// ### verilog/sarg_pkg.sv
package sarg_pkg;
  localparam int SARG_RESULT_W   = 8;
  localparam int SARG_SAMPLE_BEG = 4;
  localparam int SARG_SAMPLE_END = 8;
  localparam int SARG_CLK_MHZ    = 10;
  localparam int SARG_CONV_US    = 17;
  localparam int SARG_CONV_CYC   = SARG_CONV_US * SARG_CLK_MHZ;
  localparam int SARG_IOCLK_MAX_KHZ = 2048;
  localparam int SARG_DIV_HALF   = (SARG_CLK_MHZ * 1000 + 2 * SARG_IOCLK_MAX_KHZ - 1)
                                   / (2 * SARG_IOCLK_MAX_KHZ);
  localparam int SARG_CONV_LINK_CYC = 36;
  localparam logic SARG_SEL_ON   = 1'b0;
  localparam logic SARG_SEL_OFF  = 1'b1;
endpackage

// ### verilog/sarg_link_if.sv
`timescale 1ns/1ps
interface sarg_link_if;
  logic io_clk;
  logic select_n;
  logic data_out;
  logic data_oe;
  modport dev (input io_clk, input select_n, output data_out, output data_oe);
  modport host (output io_clk, output select_n, input data_out, input data_oe);
endinterface

// ### verilog/sarg_host.sv
`timescale 1ns/1ps
// Overview of operation
// - select low starts a readout cycle
// - capture bit before io clock falls
// - device samples from fourth to eighth fall
// - conversion at eighth fall, host waits 17us
// - select high: device ignores clock, output off
// - io clock no faster than 2.048 MHz
// - no channel address shifted in
// - select follows latched select address bit
// - each input read makes one clock pulse
// - flip-flop latches select bit on bus clock
// - qualify bit gates select latch updates; no qualify bit here, the latch changes only on a start in idle or on release
// - clock gate bit gates io clock rise; no such bit here, the divider tick times each rise in SARG_SEL and SARG_LOW
// - clock gate bit enables data onto bus; no such bit or bus here, result_o is a register loaded at release
// - select released after eight bits
// - select port pin drives select directly
// - io clock delayed for setup and hold
// - result readable after select releases
module sarg_host
  import sarg_pkg::*;
#(
  parameter int RESULT_W  = SARG_RESULT_W,
  parameter int DIV_HALF  = SARG_DIV_HALF,
  parameter int CONV_CYC  = SARG_CONV_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                start_i,
  output logic                     busy_o,
  output logic                     done_o,
  output logic [RESULT_W-1:0]      result_o,
  sarg_link_if.host                link
);
  typedef enum logic [2:0] {SARG_IDLE, SARG_SEL, SARG_HIGH, SARG_LOW, SARG_REL, SARG_WAIT}
    sarg_state_e;
  sarg_state_e                 state;
  sarg_state_e                 next_state;
  logic [7:0]                  div;
  logic [3:0]                  nbit;
  logic [15:0]                 wait_cnt;
  logic [RESULT_W-1:0]         shreg;
  logic                        select_address_bit;
  logic                        io_clk_q;
  logic                        io_clk_dly;
  logic                        d_s1;
  logic                        d_s2;
  logic                        d_s3;
  logic                        d_bit;
  wire                         tick        = (div == 8'(DIV_HALF - 1));
  wire                         last        = (nbit == 4'(RESULT_W));
  wire                         wait_zero   = (wait_cnt == 16'h0000);
  wire                         take        = (state == SARG_IDLE) && start_i;
  wire                         rise_now    = tick && ((state == SARG_SEL) ||
                                                      ((state == SARG_LOW) && !last));
  wire                         fall_now    = tick && (state == SARG_HIGH);
  wire                         release_now = (state == SARG_REL);

  // pin input, three stages; second and third must agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d_s1 <= 1'b0;
      d_s2 <= 1'b0;
      d_s3 <= 1'b0;
    end else begin
      d_s1 <= link.data_out;
      d_s2 <= d_s1;
      d_s3 <= d_s2;
    end
  end
  wire d_agree = (d_s2 == d_s3);

  // a bit in motion is never taken; the low phase leaves room for it to settle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d_bit <= 1'b0;
    end else if (d_agree) begin
      d_bit <= d_s3;
    end
  end

  assign link.select_n = select_address_bit;
  assign link.io_clk   = io_clk_dly;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_clk_dly <= 1'b0;
    end else begin
      io_clk_dly <= io_clk_q; // one clock of delay past select setup
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 8'h00;
    end else begin
      div <= tick ? 8'h00 : div + 8'h01; // half period rounded up
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      SARG_IDLE: begin
        if (start_i) begin
          next_state = SARG_SEL;
        end
      end
      SARG_SEL: begin
        if (tick) begin
          next_state = SARG_HIGH;
        end
      end
      SARG_HIGH: begin
        if (tick) begin
          next_state = SARG_LOW;
        end
      end
      SARG_LOW: begin
        if (tick) begin
          if (last) begin
            next_state = SARG_REL;
          end else begin
            next_state = SARG_HIGH;
          end
        end
      end
      SARG_REL: begin
        next_state = SARG_WAIT;
      end
      SARG_WAIT: begin
        if (wait_zero) begin
          next_state = SARG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SARG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nbit <= 4'h0;
    end else if (take) begin
      nbit <= 4'h0;
    end else if (fall_now) begin
      nbit <= nbit + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg <= '0;
    end else if (fall_now) begin
      shreg <= {shreg[RESULT_W-2:0], d_bit};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      select_address_bit <= SARG_SEL_OFF;
    end else if (take) begin
      select_address_bit <= SARG_SEL_ON;
    end else if (release_now) begin
      select_address_bit <= SARG_SEL_OFF;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_clk_q <= 1'b0;
    end else if (rise_now) begin
      io_clk_q <= 1'b1; // one pulse per bit
    end else if (fall_now) begin
      io_clk_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= 16'h0000;
    end else if (release_now) begin
      wait_cnt <= 16'(CONV_CYC);
    end else if ((state == SARG_WAIT) && !wait_zero) begin
      wait_cnt <= wait_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else if (take) begin
      busy_o <= 1'b1;
    end else if ((state == SARG_WAIT) && wait_zero) begin
      busy_o <= 1'b0; // no new frame until the conversion time is over
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= release_now;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= '0;
    end else if (release_now) begin
      result_o <= shreg;
    end
  end
endmodule

// ### verilog/sarg_dev.sv
`timescale 1ns/1ps
module sarg_dev
  import sarg_pkg::*;
#(
  parameter int RESULT_W = SARG_RESULT_W,
  parameter int CONV_LEN = SARG_CONV_LINK_CYC
) (
  input  wire logic                dev_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic [RESULT_W-1:0] analog_i,
  output logic                     sampling_o,
  output logic                     converting_o,
  sarg_link_if.dev                 link
);
  logic [RESULT_W-1:0] conv_result;
  logic [RESULT_W-1:0] held;
  logic [RESULT_W-1:0] shreg;
  logic [3:0]          falls;
  logic [7:0]          conv_cnt;
  logic                conv_tgl;
  logic                tg_s1;
  logic                tg_s2;
  logic                tg_s3;
  logic                tg_seen;

  wire active     = (link.select_n == SARG_SEL_ON);
  wire first_fall = (falls == 4'h0);
  wire in_window  = (falls >= 4'(SARG_SAMPLE_BEG - 1)) && (falls < 4'(SARG_SAMPLE_END));
  wire last_fall  = (falls == 4'(SARG_SAMPLE_END - 1));

  // select high clears the count at once, since the io clock stands still between frames
  always_ff @(negedge link.io_clk or posedge link.select_n or negedge rst_n_i) begin
    if (!rst_n_i) begin
      falls <= 4'h0;
    end else if (link.select_n == SARG_SEL_OFF) begin
      falls <= 4'h0; // inputs ignored
    end else begin
      falls <= falls + 4'h1;
    end
  end

  // frame data on the io clock's falling edge; held survives select high for the conversion
  always_ff @(negedge link.io_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg    <= '0;
      held     <= '0;
      conv_tgl <= 1'b0;
    end else if (active) begin
      if (first_fall) begin
        shreg <= {conv_result[RESULT_W-2:0], 1'b0};
      end else begin
        shreg <= {shreg[RESULT_W-2:0], 1'b0};
      end
      if (in_window) begin
        held <= analog_i;
      end
      if (last_fall) begin
        conv_tgl <= ~conv_tgl; // eighth fall starts the conversion
      end
    end
  end

  // msb sits on the line from select until the first fall
  assign link.data_out = first_fall ? conv_result[RESULT_W-1] : shreg[RESULT_W-1];
  assign link.data_oe  = active;
  assign sampling_o    = active && falls >= 4'(SARG_SAMPLE_BEG) && falls < 4'(SARG_SAMPLE_END);

  // the start toggle crosses into the internal clock through three stages
  always_ff @(posedge dev_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      tg_s1 <= conv_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end
  wire tg_agree = (tg_s2 == tg_s3);
  wire conv_go  = tg_agree && (tg_s3 != tg_seen);

  // conversion counts on the internal clock
  always_ff @(posedge dev_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tg_seen      <= 1'b0;
      conv_cnt     <= 8'h00;
      converting_o <= 1'b0;
      conv_result  <= '0;
    end else begin
      if (tg_agree) begin
        tg_seen <= tg_s3;
      end
      if (conv_go) begin
        converting_o <= 1'b1;
        conv_cnt     <= 8'(CONV_LEN);
      end else if (converting_o) begin
        if (conv_cnt == 8'h01) begin
          converting_o <= 1'b0;
          conv_result  <= held;
        end
        conv_cnt <= conv_cnt - 8'h01;
      end
    end
  end
endmodule

// ### sim/sarg_link_properties.sv
`timescale 1ns/1ps
module sarg_link_properties
  import sarg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic io_clk,
  input  wire logic select_n,
  input  wire logic data_out,
  input  wire logic data_oe
);
  logic       io_q;
  logic [3:0] falls;
  logic [15:0] gap_cnt;
  // cycles with select high; saturates so a frame after reset is not flagged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_cnt <= 16'hFFFF;
    end else if (!select_n) begin
      gap_cnt <= 16'h0000;
    end else if (gap_cnt != 16'hFFFF) begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end
  // a fall wins over the idle clear so the eighth one is still counted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_q  <= 1'b0;
      falls <= 4'h0;
    end else begin
      io_q  <= io_clk;
      falls <= (io_q && !io_clk) ? falls + 4'h1 : (select_n ? 4'h0 : falls);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence frame_open; $fell(select_n); endsequence
  sequence frame_close; $rose(select_n); endsequence
  chk_frame_start: assert property (frame_open |-> ##[0:20] $rose(io_clk))
    else $error("no io clock after select");
  chk_idle_clock: assert property (select_n |-> !io_clk)
    else $error("io clock moves while idle");
  chk_out_off: assert property (select_n && $past(select_n) |-> !data_oe)
    else $error("output driven while idle");
  chk_out_on: assert property (!select_n && !$past(select_n) |-> data_oe)
    else $error("output off in frame");
  chk_high_width: assert property ($rose(io_clk) |-> io_clk[*3])
    else $error("io clock high too short");
  chk_low_width: assert property ($fell(io_clk) && !select_n |-> (!io_clk)[*3])
    else $error("io clock low too short");
  chk_bit_stable: assert property (io_clk && $past(io_clk) |-> $stable(data_out))
    else $error("bit moved while clock high");
  chk_eight_falls: assert property (frame_close |-> ##[0:1] (falls == 4'h8))
    else $error("frame not eight clocks");
  chk_conv_gap: assert property (frame_close |-> select_n[*8])
    else $error("select back too soon");
  chk_conv_wait: assert property (frame_open |-> gap_cnt >= 16'(SARG_CONV_CYC))
    else $error("conversion time not waited");
endmodule

// ### sim/serial_adc_readout_glue_tb_top.sv
`timescale 1ns/1ps
module serial_adc_readout_glue_tb_top;
  import sarg_pkg::*;
  logic       clk_i = 1'b0, dev_clk = 1'b0, rst_n_i = 1'b0, start_i = 1'b0;
  logic       busy_o, done_o, sampling_o, converting_o;
  logic       saw_samp = 1'b0, saw_conv = 1'b0;
  logic [7:0] analog = 8'h00, result_o;
  int         mismatches = 0, n_tests = 0, cycles = 0;
  sarg_link_if link ();
  always #50 clk_i = ~clk_i;
  // odd start offset keeps the device clock out of step with the host clock
  initial begin
    #3.7;
    forever #6 dev_clk = ~dev_clk;
  end
  sarg_host sarg_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .link(link));
  sarg_dev sarg_dev_inst (.dev_clk_i(dev_clk), .rst_n_i(rst_n_i), .analog_i(analog),
    .sampling_o(sampling_o), .converting_o(converting_o), .link(link));
  sarg_link_properties sarg_link_properties_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .io_clk(link.io_clk), .select_n(link.select_n), .data_out(link.data_out),
    .data_oe(link.data_oe));
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (sampling_o === 1'b1) saw_samp <= 1'b1;
    if (converting_o === 1'b1) saw_conv <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic frame(input logic [7:0] v, input logic [7:0] exp, input bit poke);
    int n;
    n = 0;
    @(posedge clk_i);
    analog <= v;
    start_i <= 1'b1;
    saw_samp <= 1'b0;
    saw_conv <= 1'b0;
    @(posedge clk_i);
    start_i <= 1'b0;
    if (poke) begin
      repeat (10) @(posedge clk_i);
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
    end
    do begin @(posedge clk_i); #1; n++; end while (done_o !== 1'b1 && n < 400);
    check(result_o === exp, "result");
    check(saw_samp === 1'b1 && busy_o === 1'b1, "sample window");
    n = 0;
    do begin @(posedge clk_i); #1; n++; end while (busy_o !== 1'b0 && n < 400);
    check(saw_conv === 1'b1 && n >= SARG_CONV_CYC && n < 400, "conversion wait");
  endtask
  task test_stream;
    frame(8'hA5, 8'h00, 1'b0);
    frame(8'h5A, 8'hA5, 1'b0);
    frame(8'h80, 8'h5A, 1'b0);
    frame(8'h01, 8'h80, 1'b0);
    $display("test_stream done");
  endtask
  task test_refuse;
    frame(8'hFF, 8'h01, 1'b1);
    repeat (30) begin
      @(posedge clk_i);
      #1;
      check(busy_o === 1'b0 && link.select_n === 1'b1, "extra start taken");
    end
    $display("test_refuse done");
  endtask
  task test_reset_mid;
    @(posedge clk_i);
    analog <= 8'hC3;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check(link.select_n === 1'b1 && link.io_clk === 1'b0 && link.data_oe === 1'b0, "idle");
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    frame(8'h3C, 8'h00, 1'b0);
    $display("test_reset_mid done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    test_stream();
    test_refuse();
    test_reset_mid();
    end_sim();
  end
endmodule
